// [irq_ctrl_cfg.svh]
/*
 * Addresses, reset values, bit positions and request-vector indices for
 * the interrupt enable and request-flag block.
 * Assumes it is included by bare name from design files of this block.
 */
`ifndef IRQ_CTRL_CFG_SVH
`define IRQ_CTRL_CFG_SVH

`define ADDR_EDGE_SELECT   16'hFFF2
`define ADDR_ENABLE_FIRST  16'hFFF3
`define ADDR_ENABLE_SECOND 16'hFFF4
`define ADDR_REQUEST_FIRST 16'hFFF6

`define RESET_EDGE_SELECT  8'hE0
`define RESET_ENABLE       8'h00
`define RESET_REQUEST      8'h20
`define FIXED_ONES_EDGE    8'hE0
`define FIXED_ONES_REQUEST 8'h20
`define READ_UNMAPPED      8'h00
`define PIN_IDLE_LEVEL     5'h1F

`define BIT_TIMER_A        7
`define BIT_SERIAL1        6
`define BIT_WAKEUP         5
`define BIT_RESERVED_REQ   5
`define BIT_EXT_PIN2       2
`define BIT_DIRECT         7
`define BIT_ADC            6
`define BIT_RSVD_HI        5
`define BIT_RSVD_LO        4
`define BIT_TIMER_FH       3
`define BIT_TIMER_FL       2
`define BIT_TIMER_C        1
`define BIT_TIMER_B        0
`define EXT_PINS           5

`define REQ_EXT_LSB        0
`define REQ_EXT_MSB        4
`define REQ_WAKEUP         5
`define REQ_SERIAL1        6
`define REQ_TIMER_A        7
`define REQ_TIMER_B        8
`define REQ_TIMER_C        9
`define REQ_TIMER_FL       10
`define REQ_TIMER_FH       11
`define REQ_ADC            12
`define REQ_DIRECT         13
`define REQ_COUNT          14

`endif

// [irq_ctrl_pkg.sv]
/*
 * Types shared by both ends of the interrupt enable and flag block.
 * Assumes irq_ctrl_cfg.svh supplies the request count.
 */
`include "irq_ctrl_cfg.svh"
package irq_ctrl_pkg;
	typedef logic [15:0]            addr_t;
	typedef logic [7:0]             byte_t;
	typedef logic [`REQ_COUNT-1:0]  req_vec_t;
endpackage : irq_ctrl_pkg

// [irq_bus_if.sv]
/*
 * Register port and request lines between the interrupt block and the CPU.
 * Assumes both ends share sys_clk_in; the testbench instantiates this.
 */
`timescale 1ns/1ps
`default_nettype none
interface irq_bus_if;
	irq_ctrl_pkg::addr_t    reg_addr;
	irq_ctrl_pkg::byte_t    reg_wdata;
	logic                   reg_wr;
	logic                   reg_rd;
	irq_ctrl_pkg::byte_t    reg_rdata;
	irq_ctrl_pkg::req_vec_t int_req;

	modport device (
		input  reg_addr,
		input  reg_wdata,
		input  reg_wr,
		input  reg_rd,
		output reg_rdata,
		output int_req
	);
	modport host (
		output reg_addr,
		output reg_wdata,
		output reg_wr,
		output reg_rd,
		input  reg_rdata,
		input  int_req
	);
endinterface : irq_bus_if
`default_nettype wire

// [irq_ctrl_device.sv]
/*
 * Interrupt enable registers, edge-select register and first request-flag
 * register, with per-source gating of requests toward the CPU.
 * Assumes one clock, synchronous reset, a CPU end on irq_bus_if, external
 * IRQ pins asynchronous, all other event inputs on sys_clk_in.
 */
// Summary of operation
// RULE_01: first enable register, 8 bits, resets zero
// RULE_02: enable bit 7 gates timer A overflow
// RULE_03: enable bit 6 gates serial one transfer
// RULE_04: enable bit 5 gates all wakeup pins
// RULE_05: enable bits 4,3,1,0 gate external pins
// RULE_06: enable bit 2 gates external pin 2
// RULE_07: second enable register; bit 7 direct transfer
// RULE_08: second enable bit 6 gates converter end
// RULE_09: enable bits 5,4 stored; software writes 0
// RULE_10: second enable bit 3 gates timer FH
// RULE_11: second enable bit 2 gates timer FL
// RULE_12: second enable bit 1 gates timer C
// RULE_13: second enable bit 0 gates timer B
// RULE_14: request flags clear on 0, ignore 1
// RULE_15: acceptance never clears flags; software does
// RULE_16: timer A wrap sets request bit 7
// RULE_17: serial one completion sets request bit 6
// RULE_18: request bit 5 reads 1, others reset 0
// RULE_19: pin edge sets flag when pin is interrupt
// RULE_20: edge select: 0 falling, 1 rising per pin
// RULE_21: request presented while flag and enable both set
`include "irq_ctrl_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module irq_ctrl_device (
	input  wire logic                   sys_clk_in,
	input  wire logic                   reset_in,
	irq_bus_if.device                   bus,
	input  wire logic                   timer_a_wrap_in,
	input  wire logic                   serial1_done_in,
	input  wire logic [`EXT_PINS-1:0]   ext_pin_in,
	input  wire logic [`EXT_PINS-1:0]   pin_is_irq_in,
	input  wire logic [7:0]             wakeup_flags_in,
	input  wire logic [7:0]             second_flags_in,
	output logic [7:0]                  edge_select_out
);

	irq_ctrl_pkg::byte_t    edge_select_reg;
	irq_ctrl_pkg::byte_t    irq_enable_first;
	irq_ctrl_pkg::byte_t    irq_enable_second;
	irq_ctrl_pkg::byte_t    irq_request_flags_first;
	irq_ctrl_pkg::byte_t    next_edge_select_reg;
	irq_ctrl_pkg::byte_t    next_irq_enable_first;
	irq_ctrl_pkg::byte_t    next_irq_enable_second;
	irq_ctrl_pkg::byte_t    next_irq_request_flags_first;
	irq_ctrl_pkg::byte_t    rdata;
	irq_ctrl_pkg::byte_t    next_rdata;
	irq_ctrl_pkg::req_vec_t int_req;
	irq_ctrl_pkg::req_vec_t next_int_req;
	logic [`EXT_PINS-1:0]   pin_meta;
	logic [`EXT_PINS-1:0]   pin_sync;
	logic [`EXT_PINS-1:0]   pin_prev;
	logic [`EXT_PINS-1:0]   pin_edge;
	irq_ctrl_pkg::byte_t    flag_set;
	irq_ctrl_pkg::byte_t    flag_clr;

	function automatic logic addr_hit(input irq_ctrl_pkg::addr_t a,
		input irq_ctrl_pkg::addr_t target);
		addr_hit = (a == target);
	endfunction : addr_hit

	assign bus.reg_rdata = rdata;
	assign bus.int_req   = int_req;

	// pin synchroniser and edge history; idle high matches inactive pins
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			pin_meta <= `PIN_IDLE_LEVEL;
			pin_sync <= `PIN_IDLE_LEVEL;
			pin_prev <= `PIN_IDLE_LEVEL;
		end else begin
			pin_meta <= ext_pin_in;
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
		end
	end

	genvar i;
	generate
		for (i = 0; i < `EXT_PINS; i++) begin : g_edge
			// polarity picked per pin by the edge-select bit
			assign pin_edge[i] = pin_is_irq_in[i] & (edge_select_reg[i] ?
				(pin_sync[i] & ~pin_prev[i]) :
				(~pin_sync[i] & pin_prev[i])); // [RULE_19] [RULE_20]
		end
	endgenerate

	// register writes
	always_comb begin
		next_edge_select_reg   = edge_select_reg;
		next_irq_enable_first  = irq_enable_first;
		next_irq_enable_second = irq_enable_second;
		if (bus.reg_wr && addr_hit(bus.reg_addr, `ADDR_EDGE_SELECT)) begin
			next_edge_select_reg = bus.reg_wdata; // [RULE_20]
		end
		if (bus.reg_wr && addr_hit(bus.reg_addr, `ADDR_ENABLE_FIRST)) begin
			next_irq_enable_first = bus.reg_wdata; // [RULE_01]
		end
		if (bus.reg_wr && addr_hit(bus.reg_addr, `ADDR_ENABLE_SECOND)) begin
			// bits 5 and 4 kept as plain storage
			next_irq_enable_second = bus.reg_wdata; // [RULE_07] [RULE_09]
		end
		// the top three edge-select bits are fixed at one
		next_edge_select_reg = next_edge_select_reg | `FIXED_ONES_EDGE;
	end

	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			edge_select_reg   <= `RESET_EDGE_SELECT;
			irq_enable_first  <= `RESET_ENABLE; // [RULE_01]
			irq_enable_second <= `RESET_ENABLE; // [RULE_07]
		end else begin
			edge_select_reg   <= next_edge_select_reg;
			irq_enable_first  <= next_irq_enable_first;
			irq_enable_second <= next_irq_enable_second;
		end
	end

	// request flags: hardware set wins over a software clear
	always_comb begin
		flag_set = 8'h00;
		flag_set[`BIT_TIMER_A] = timer_a_wrap_in; // [RULE_16]
		flag_set[`BIT_SERIAL1] = serial1_done_in; // [RULE_17]
		flag_set[`EXT_PINS-1:0] = pin_edge; // [RULE_19]
		flag_clr = 8'h00;
		if (bus.reg_wr && addr_hit(bus.reg_addr, `ADDR_REQUEST_FIRST)) begin
			flag_clr = ~bus.reg_wdata; // [RULE_14]
		end
		// nothing clears on acceptance, only a written zero
		next_irq_request_flags_first =
			(irq_request_flags_first & ~flag_clr) | flag_set; // [RULE_15]
		next_irq_request_flags_first = next_irq_request_flags_first |
			`FIXED_ONES_REQUEST; // [RULE_18]
	end

	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			irq_request_flags_first <= `RESET_REQUEST; // [RULE_18]
		end else begin
			irq_request_flags_first <= next_irq_request_flags_first;
		end
	end

	// read data, registered one cycle after the read strobe
	always_comb begin
		next_rdata = rdata;
		if (bus.reg_rd) begin
			if (addr_hit(bus.reg_addr, `ADDR_EDGE_SELECT)) begin
				next_rdata = edge_select_reg;
			end else if (addr_hit(bus.reg_addr, `ADDR_ENABLE_FIRST)) begin
				next_rdata = irq_enable_first;
			end else if (addr_hit(bus.reg_addr, `ADDR_ENABLE_SECOND)) begin
				next_rdata = irq_enable_second;
			end else if (addr_hit(bus.reg_addr, `ADDR_REQUEST_FIRST)) begin
				next_rdata = irq_request_flags_first;
			end else begin
				next_rdata = `READ_UNMAPPED;
			end
		end
	end

	// gated requests toward the CPU
	always_comb begin
		next_int_req = '0;
		next_int_req[`REQ_EXT_MSB:`REQ_EXT_LSB] =
			irq_request_flags_first[`EXT_PINS-1:0] &
			irq_enable_first[`EXT_PINS-1:0]; // [RULE_05] [RULE_06] [RULE_21]
		next_int_req[`REQ_WAKEUP] = (|wakeup_flags_in) &
			irq_enable_first[`BIT_WAKEUP]; // [RULE_04]
		next_int_req[`REQ_SERIAL1] = irq_request_flags_first[`BIT_SERIAL1] &
			irq_enable_first[`BIT_SERIAL1]; // [RULE_03]
		next_int_req[`REQ_TIMER_A] = irq_request_flags_first[`BIT_TIMER_A] &
			irq_enable_first[`BIT_TIMER_A]; // [RULE_02]
		next_int_req[`REQ_TIMER_B] = second_flags_in[`BIT_TIMER_B] &
			irq_enable_second[`BIT_TIMER_B]; // [RULE_13]
		next_int_req[`REQ_TIMER_C] = second_flags_in[`BIT_TIMER_C] &
			irq_enable_second[`BIT_TIMER_C]; // [RULE_12]
		next_int_req[`REQ_TIMER_FL] = second_flags_in[`BIT_TIMER_FL] &
			irq_enable_second[`BIT_TIMER_FL]; // [RULE_11]
		next_int_req[`REQ_TIMER_FH] = second_flags_in[`BIT_TIMER_FH] &
			irq_enable_second[`BIT_TIMER_FH]; // [RULE_10]
		next_int_req[`REQ_ADC] = second_flags_in[`BIT_ADC] &
			irq_enable_second[`BIT_ADC]; // [RULE_08]
		next_int_req[`REQ_DIRECT] = second_flags_in[`BIT_DIRECT] &
			irq_enable_second[`BIT_DIRECT]; // [RULE_07]
	end

	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			rdata           <= `READ_UNMAPPED;
			int_req         <= '0;
			edge_select_out <= `RESET_EDGE_SELECT;
		end else begin
			rdata           <= next_rdata;
			int_req         <= next_int_req; // [RULE_21]
			edge_select_out <= next_edge_select_reg;
		end
	end

endmodule : irq_ctrl_device
`default_nettype wire

// [irq_ctrl_host.sv]
/*
 * CPU end of the interrupt block: turns a command port into register
 * strobes and returns read data and the gated requests.
 * Assumes the device end answers a read one cycle after the strobe.
 */
`include "irq_ctrl_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module irq_ctrl_host #(
	parameter bit SMALL_VARIANT = 1'b0
) (
	input  wire logic                    sys_clk_in,
	input  wire logic                    reset_in,
	irq_bus_if.host                      bus,
	input  wire logic                    cmd_valid_in,
	input  wire logic                    cmd_write_in,
	input  wire logic [15:0]             cmd_addr_in,
	input  wire logic [7:0]              cmd_wdata_in,
	output logic [7:0]                   rd_data_out,
	output logic                         rd_valid_out,
	output logic [`REQ_COUNT-1:0]        int_req_out
);

	irq_ctrl_pkg::addr_t addr;
	irq_ctrl_pkg::byte_t wdata;
	logic                wr;
	logic                rd;
	logic                rd_pend;
	irq_ctrl_pkg::byte_t next_wdata;

	assign bus.reg_addr  = addr;
	assign bus.reg_wdata = wdata;
	assign bus.reg_wr    = wr;
	assign bus.reg_rd    = rd;

	// software-side duties: reserved and absent bits written as zero
	always_comb begin
		next_wdata = cmd_wdata_in;
		if (cmd_addr_in == `ADDR_ENABLE_SECOND) begin
			next_wdata[`BIT_RSVD_HI] = 1'b0; // [RULE_09]
			next_wdata[`BIT_RSVD_LO] = 1'b0; // [RULE_09]
		end
		if (SMALL_VARIANT) begin
			case (cmd_addr_in)
				`ADDR_ENABLE_FIRST: begin
					next_wdata[`BIT_SERIAL1]  = 1'b0; // [RULE_03]
					next_wdata[`BIT_EXT_PIN2] = 1'b0; // [RULE_06]
				end
				`ADDR_ENABLE_SECOND: begin
					next_wdata[`BIT_TIMER_C] = 1'b0; // [RULE_12]
				end
				`ADDR_REQUEST_FIRST: begin
					next_wdata[`BIT_SERIAL1] = 1'b0; // [RULE_17]
				end
				`ADDR_EDGE_SELECT: begin
					next_wdata[`BIT_EXT_PIN2] = 1'b0;
				end
				default: begin
					next_wdata = next_wdata;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			addr         <= '0;
			wdata        <= '0;
			wr           <= 1'b0;
			rd           <= 1'b0;
			rd_pend      <= 1'b0;
			rd_data_out  <= '0;
			rd_valid_out <= 1'b0;
			int_req_out  <= '0;
		end else begin
			addr         <= cmd_addr_in;
			wdata        <= next_wdata;
			wr           <= cmd_valid_in & cmd_write_in; // [RULE_15]
			rd           <= cmd_valid_in & ~cmd_write_in;
			rd_pend      <= rd;
			rd_data_out  <= rd_pend ? bus.reg_rdata : rd_data_out;
			rd_valid_out <= rd_pend;
			int_req_out  <= bus.int_req;
		end
	end

endmodule : irq_ctrl_host
`default_nettype wire

// [irq_monitor.sv]
/* Concurrent checks on the register port and request lines.
   Assumes one clock and the register addresses of irq_ctrl_cfg.svh. */
`include "irq_ctrl_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module irq_monitor (
	input  wire logic                   sys_clk_in,
	input  wire logic                   reset_in,
	input  wire irq_ctrl_pkg::addr_t    reg_addr,
	input  wire irq_ctrl_pkg::byte_t    reg_wdata,
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	input  wire irq_ctrl_pkg::byte_t    reg_rdata,
	input  wire irq_ctrl_pkg::req_vec_t int_req
);
	logic [7:0]  sh1;
	logic [7:0]  sh2;
	logic [7:0]  next_sh1;
	logic [7:0]  next_sh2;
	logic [13:0] en_vec;
	// shadow copies of both enable registers, taken from the write strobes
	always_comb begin
		next_sh1 = sh1;
		next_sh2 = sh2;
		if (reg_wr && reg_addr == `ADDR_ENABLE_FIRST) next_sh1 = reg_wdata;
		if (reg_wr && reg_addr == `ADDR_ENABLE_SECOND) next_sh2 = reg_wdata;
		if (reset_in) next_sh1 = 8'h00;
		if (reset_in) next_sh2 = 8'h00;
	end
	always_ff @(posedge sys_clk_in) begin
		sh1 <= next_sh1;
		sh2 <= next_sh2;
	end
	assign en_vec = {sh2[7:6], sh2[3:0], sh1};
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (reset_in);
	rst_clear_a: assert property ($fell(reset_in) |-> int_req == '0)
		else $error("requests present after reset");
	en1_read_a: assert property (reg_rd && reg_addr == `ADDR_ENABLE_FIRST
		|=> reg_rdata == sh1) else $error("first enable readback wrong");
	en2_read_a: assert property (reg_rd && reg_addr == `ADDR_ENABLE_SECOND
		|=> reg_rdata == sh2) else $error("second enable readback wrong");
	rsvd_bit_a: assert property (reg_rd && reg_addr == `ADDR_REQUEST_FIRST
		|=> reg_rdata[5]) else $error("reserved request bit not one");
	gate_mask_a: assert property ((int_req & ~$past(en_vec)) == '0)
		else $error("request passed a cleared enable");
	en1_off_a: assert property (reg_wr && reg_addr == `ADDR_ENABLE_FIRST
		&& reg_wdata == 8'h00 |-> ##2 int_req[7:0] == '0)
		else $error("first enable cleared but requests stay");
	en2_off_a: assert property (reg_wr && reg_addr == `ADDR_ENABLE_SECOND
		&& reg_wdata == 8'h00 |-> ##2 int_req[13:8] == '0)
		else $error("second enable cleared but requests stay");
	unmap_read_a: assert property (reg_rd && !(reg_addr inside {`ADDR_EDGE_SELECT,
		`ADDR_ENABLE_FIRST, `ADDR_ENABLE_SECOND, `ADDR_REQUEST_FIRST})
		|=> reg_rdata == 8'h00) else $error("unmapped read not zero");
	rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved without a read");
	cover property (int_req[7] && int_req[13]);
	cover property (reg_rd && reg_addr == `ADDR_REQUEST_FIRST);
	cover property (int_req[4:0] == 5'h1F);
endmodule : irq_monitor
`default_nettype wire

// [interrupt_enable_and_request_flags_tb.sv]
/* Self-checking bench: host and device ends joined by irq_bus_if.
   Assumes the design files and irq_monitor are compiled first. */
`include "irq_ctrl_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module interrupt_enable_and_request_flags_tb;
	logic        sys_clk_in      = 1'b0;
	logic        reset_in        = 1'b1;
	logic        timer_a_wrap_in = 1'b0;
	logic        serial1_done_in = 1'b0;
	logic [4:0]  ext_pin_in      = 5'h1F;
	logic [4:0]  pin_is_irq_in   = 5'h1F;
	logic [7:0]  wakeup_flags_in = 8'h00;
	logic [7:0]  second_flags_in = 8'h00;
	logic        cmd_valid_in    = 1'b0;
	logic        cmd_write_in    = 1'b0;
	logic [15:0] cmd_addr_in     = 16'h0000;
	logic [7:0]  cmd_wdata_in    = 8'h00;
	logic [7:0]  edge_select_out;
	logic [7:0]  rd_data_out;
	logic        rd_valid_out;
	logic [13:0] int_req_out;
	logic [7:0]  rd_data_small;
	int          err_count       = 0;
	int          tests_run       = 0;
	irq_bus_if bus ();
	irq_bus_if bus_small ();
	irq_ctrl_device u_irq_ctrl_device (.sys_clk_in(sys_clk_in),
		.reset_in(reset_in), .bus(bus), .timer_a_wrap_in(timer_a_wrap_in),
		.serial1_done_in(serial1_done_in), .ext_pin_in(ext_pin_in),
		.pin_is_irq_in(pin_is_irq_in), .wakeup_flags_in(wakeup_flags_in),
		.second_flags_in(second_flags_in), .edge_select_out(edge_select_out));
	irq_ctrl_host #(.SMALL_VARIANT(1'b0)) u_irq_ctrl_host (
		.sys_clk_in(sys_clk_in), .reset_in(reset_in), .bus(bus),
		.cmd_valid_in(cmd_valid_in), .cmd_write_in(cmd_write_in),
		.cmd_addr_in(cmd_addr_in), .cmd_wdata_in(cmd_wdata_in),
		.rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out),
		.int_req_out(int_req_out));
	irq_monitor u_irq_monitor (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
		.reg_addr(bus.reg_addr), .reg_wdata(bus.reg_wdata), .reg_wr(bus.reg_wr),
		.reg_rd(bus.reg_rd), .reg_rdata(bus.reg_rdata), .int_req(bus.int_req));
	// smaller variant pair, fed the same commands and events
	irq_ctrl_device u_irq_ctrl_device_small (.sys_clk_in(sys_clk_in),
		.reset_in(reset_in), .bus(bus_small),
		.timer_a_wrap_in(timer_a_wrap_in),
		.serial1_done_in(serial1_done_in), .ext_pin_in(ext_pin_in),
		.pin_is_irq_in(pin_is_irq_in), .wakeup_flags_in(wakeup_flags_in),
		.second_flags_in(second_flags_in), .edge_select_out());
	irq_ctrl_host #(.SMALL_VARIANT(1'b1)) u_irq_ctrl_host_small (
		.sys_clk_in(sys_clk_in), .reset_in(reset_in), .bus(bus_small),
		.cmd_valid_in(cmd_valid_in), .cmd_write_in(cmd_write_in),
		.cmd_addr_in(cmd_addr_in), .cmd_wdata_in(cmd_wdata_in),
		.rd_data_out(rd_data_small), .rd_valid_out(),
		.int_req_out());
	always #20 sys_clk_in = ~sys_clk_in;
	task automatic conclude();
		if (err_count == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : conclude
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			$display("MISMATCH %s expected %h seen %h", n, e, g);
			err_count++;
		end
	endtask : chk
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge sys_clk_in);
		cmd_valid_in <= 1'b1;
		cmd_write_in <= 1'b1;
		cmd_addr_in <= a;
		cmd_wdata_in <= d;
		@(posedge sys_clk_in);
		cmd_valid_in <= 1'b0;
		repeat (3) @(posedge sys_clk_in);
	endtask : wr
	task automatic rd(input logic [15:0] a, input logic [7:0] e, input string n);
		int i;
		@(posedge sys_clk_in);
		cmd_valid_in <= 1'b1;
		cmd_write_in <= 1'b0;
		cmd_addr_in <= a;
		@(posedge sys_clk_in);
		cmd_valid_in <= 1'b0;
		for (i = 0; i < 8 && rd_valid_out !== 1'b1; i++) @(negedge sys_clk_in);
		if (i == 8) begin
			err_count++;
			conclude();
		end else begin
			chk(n, {8'h00, e}, {8'h00, rd_data_out});
		end
	endtask : rd
	task automatic settle(input logic [13:0] e);
		repeat (8) @(posedge sys_clk_in);
		@(negedge sys_clk_in);
		chk("int_req_out", {2'b00, e}, {2'b00, int_req_out});
	endtask : settle
	initial begin
		repeat (5000) @(posedge sys_clk_in);
		err_count++;
		conclude();
	end
	initial begin
		repeat (5) @(posedge sys_clk_in);
		reset_in <= 1'b0;
		rd(`ADDR_ENABLE_FIRST, 8'h00, "en1 reset");
		rd(`ADDR_ENABLE_SECOND, 8'h00, "en2 reset");
		rd(`ADDR_REQUEST_FIRST, 8'h20, "req1 reset");
		rd(`ADDR_EDGE_SELECT, 8'hE0, "edge reset");
		rd(16'hFFF5, 8'h00, "unmapped");
		wr(`ADDR_ENABLE_FIRST, 8'hFF);
		wr(`ADDR_ENABLE_SECOND, 8'hFF);
		rd(`ADDR_ENABLE_FIRST, 8'hFF, "en1");
		chk("small en1", 16'h00BB, {8'h00, rd_data_small});
		rd(`ADDR_ENABLE_SECOND, 8'hCF, "en2");
		chk("small en2", 16'h00CD, {8'h00, rd_data_small});
		@(posedge sys_clk_in);
		timer_a_wrap_in <= 1'b1;
		serial1_done_in <= 1'b1;
		ext_pin_in <= 5'h00;
		@(posedge sys_clk_in);
		timer_a_wrap_in <= 1'b0;
		serial1_done_in <= 1'b0;
		settle(14'h00DF);
		rd(`ADDR_REQUEST_FIRST, 8'hFF, "req1 set");
		wakeup_flags_in <= 8'h80;
		second_flags_in <= 8'hFF;
		settle(14'h3FFF);
		wr(`ADDR_ENABLE_FIRST, 8'h00);
		settle(14'h3F00);
		rd(`ADDR_REQUEST_FIRST, 8'hFF, "req1 kept");
		wr(`ADDR_ENABLE_SECOND, 8'h00);
		settle(14'h0000);
		wr(`ADDR_ENABLE_FIRST, 8'hFF);
		wr(`ADDR_REQUEST_FIRST, 8'hFF);
		rd(`ADDR_REQUEST_FIRST, 8'hFF, "req1 ones");
		wr(`ADDR_REQUEST_FIRST, 8'h00);
		rd(`ADDR_REQUEST_FIRST, 8'h20, "req1 clear");
		wr(`ADDR_EDGE_SELECT, 8'h1F);
		chk("edge_select_out", 16'h00FF, {8'h00, edge_select_out});
		ext_pin_in <= 5'h1F;
		settle(14'h003F);
		rd(`ADDR_REQUEST_FIRST, 8'h3F, "req1 rise");
		wr(`ADDR_REQUEST_FIRST, 8'h00);
		pin_is_irq_in <= 5'h00;
		ext_pin_in <= 5'h00;
		repeat (4) @(posedge sys_clk_in);
		ext_pin_in <= 5'h1F;
		// let a rising edge pass the synchroniser before reading the flags
		repeat (4) @(posedge sys_clk_in);
		rd(`ADDR_REQUEST_FIRST, 8'h20, "req1 not irq");
		conclude();
	end
endmodule : interrupt_enable_and_request_flags_tb
`default_nettype wire
